/* rtl/acc_top.sv */
// converter trigger, standby and conflict control with AHB-Lite register slave
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.svh"
// Summary of operation
// R1: clearing run during a conversion stops it and stores no result.
// R2: a new timer trigger during a conversion restarts it from that trigger.
// R3: abandoned conversions store nothing; every accepted trigger is counted; finished value is stored.
// R4: halt standby keeps converting; mode and result registers keep values.
// R5: idle or stop standby freezes conversion; registers keep their contents.
// R6: conversion frozen by idle or stop resumes later; its result is flagged undefined.
// R7: compare match starts conversion and raises its own maskable interrupt status.
// R8: result write colliding with a read of that register waits one cycle.
// R9: external trigger edges are ignored while converting, including the write cycle.
// R10: mode1 or channel write right after a result write suppresses done interrupt.
// R11: software spaces triggers wider than the selected conversion time.
// R12: every result is ten bits wide.
// R13: software avoids port reads on analog pins during conversion.
// R14: trigger source field value binary 10 selects external trigger mode.
// R15: external trigger edge is rising, falling or both per edge field.
// R16: one-buffer mode raises done after each conversion and then ends.
// R17: a conversion-active flag qualifies trigger acceptance and result storage.
module acc_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic compare_match_trigger,
  input wire logic external_trigger_pin,
  input wire logic nmi_release,
  input wire acc_pkg::acc_res_t analog_sample,
  output logic irq,
  output logic conv_active
);
  import acc_pkg::*;

  acc_state_s s_q;
  acc_state_s s_d;

  function automatic logic [15:0] conv_cycles(input logic [2:0] fr);
    conv_cycles = `ACC_CONV_BASE << fr;
  endfunction

  logic aph;
  logic rd_go;
  logic wr_dp;
  logic [7:0] a8;
  logic gated;
  logic src_tim;
  logic src_ext;
  logic ext_edge;
  logic tim_go;
  logic ext_go;
  logic sw_go;
  logic stop_wr;
  logic rd_hit;
  logic commit;
  logic cfg_wr;
  logic [3:0] set_v;
  logic [31:0] rd_v;

  always_comb
  begin
    aph = hsel & hready & htrans[1];
    rd_go = aph & ~hwrite;
    a8 = haddr[7:0];
    wr_dp = s_q.dp_wr;
    // idle and stop gate the converter clock, halt does not
    gated = s_q.sby[1];
    src_tim = s_q.mode1[`ACC_M1_SRC] == `ACC_SRC_TIMER;
    // R14: source field 10 picks the external pin
    src_ext = s_q.mode1[`ACC_M1_SRC] == `ACC_SRC_EXT;
    // R15: edge select
    case (s_q.mode1[`ACC_M1_EDGE])
      `ACC_EDGE_RISE: ext_edge = external_trigger_pin & ~s_q.ext_q;
      `ACC_EDGE_FALL: ext_edge = ~external_trigger_pin & s_q.ext_q;
      default: ext_edge = external_trigger_pin ^ s_q.ext_q;
    endcase
    tim_go = compare_match_trigger & src_tim & s_q.mode0[`ACC_M0_RUN] & ~gated;
    // R9: edges during a conversion or its result write are dropped
    ext_go = ext_edge & src_ext & s_q.mode0[`ACC_M0_RUN] & ~gated & (s_q.st == ACC_IDLE);
    sw_go = wr_dp & (s_q.dp_addr == `ACC_OFF_MODE0) & hwdata[`ACC_M0_RUN]
            & (s_q.mode1[`ACC_M1_SRC] == `ACC_SRC_SW) & ~gated & (s_q.st == ACC_IDLE);
    stop_wr = wr_dp & (s_q.dp_addr == `ACC_OFF_MODE0) & ~hwdata[`ACC_M0_RUN];
    // R8: a read of the same result register in this cycle goes first
    rd_hit = rd_go & (a8[7:5] == `ACC_RES_HI) & (a8[4:2] == s_q.widx);
    commit = s_q.wpend & ~rd_hit & ~stop_wr;
    cfg_wr = wr_dp & ((s_q.dp_addr == `ACC_OFF_MODE1) | (s_q.dp_addr == `ACC_OFF_CHSEL));
    rd_v = 32'h0000_0000;
    case (a8)
      `ACC_OFF_MODE0: rd_v = {24'h00_0000, s_q.mode0};
      `ACC_OFF_MODE1: rd_v = {24'h00_0000, s_q.mode1};
      `ACC_OFF_CHSEL: rd_v = {29'h0000_0000, s_q.chsel};
      `ACC_OFF_STAT: rd_v = {8'h00, s_q.tcnt, 7'h00, s_q.st == ACC_CONV, 4'h0, s_q.stat};
      `ACC_OFF_MASK: rd_v = {28'h000_0000, s_q.mask};
      `ACC_OFF_SBY: rd_v = {30'h0000_0000, s_q.sby};
      default:
      begin
        if (a8[7:5] == `ACC_RES_HI)
          rd_v = {22'h00_0000, s_q.res[a8[4:2]]};
      end
    endcase

    s_d = s_q;
    set_v = 4'h0;
    s_d.ready = 1'b1;
    s_d.ext_q = external_trigger_pin;
    s_d.dp_wr = aph & hwrite;
    if (aph)
      s_d.dp_addr = a8;
    if (rd_go)
      s_d.rdata = rd_v;
    // R7: compare match is also an ordinary cpu interrupt, masked by its mask bit
    if (compare_match_trigger)
      set_v[`ACC_ST_CMP] = 1'b1;

    if (wr_dp)
    begin
      case (s_q.dp_addr)
        `ACC_OFF_MODE0: s_d.mode0 = hwdata[7:0];
        `ACC_OFF_MODE1: s_d.mode1 = hwdata[7:0];
        `ACC_OFF_CHSEL: s_d.chsel = hwdata[2:0];
        `ACC_OFF_MASK: s_d.mask = hwdata[3:0];
        `ACC_OFF_SBY: s_d.sby = hwdata[1:0];
        default: s_d.sby = s_q.sby;
      endcase
    end
    // R4: nmi releases standby, registers untouched
    if (nmi_release)
      s_d.sby = 2'h0;

    // R10: done interrupt dropped when config is written right after the store
    s_d.dpend = 1'b0;
    if (s_q.dpend & ~cfg_wr)
      set_v[`ACC_ST_DONE] = 1'b1;

    // R3: every accepted trigger is counted
    if (tim_go | ext_go | sw_go)
      s_d.tcnt = s_q.tcnt + 8'h01;

    case (s_q.st)
      ACC_IDLE:
      begin
        if (tim_go | ext_go | sw_go)
        begin
          // R17: flag set on start
          s_d.st = ACC_CONV;
          s_d.cyc = conv_cycles(s_q.mode1[`ACC_M1_FR]);
          s_d.susp = 1'b0;
        end
      end
      ACC_CONV:
      begin
        if (stop_wr)
        begin
          // R1: stop at once, nothing stored
          s_d.st = ACC_IDLE;
          s_d.wpend = 1'b0;
        end
        else if (s_q.wpend)
        begin
          if (commit)
          begin
            // R3: the conversion that finished is stored
            s_d.res[s_q.widx] = s_q.wval;
            s_d.wpend = 1'b0;
            s_d.dpend = 1'b1;
            // R16: one-buffer operation ends after each conversion
            s_d.st = ACC_IDLE;
          end
        end
        else if (tim_go)
        begin
          // R2: restart from the latest trigger
          s_d.cyc = conv_cycles(s_q.mode1[`ACC_M1_FR]);
          s_d.susp = 1'b0;
          set_v[`ACC_ST_ABAND] = 1'b1;
        end
        else if (gated)
          // R5: converter clock stopped, count frozen
          s_d.susp = 1'b1;
        else if (s_q.cyc == 16'h0001)
        begin
          // R12: ten-bit result latched for storing
          s_d.wpend = 1'b1;
          s_d.wval = analog_sample;
          s_d.widx = s_q.chsel;
          // R6: result after a frozen conversion is marked undefined
          set_v[`ACC_ST_SUSP] = s_q.susp;
        end
        else
          // R4: halt keeps counting
          s_d.cyc = s_q.cyc - 16'h0001;
      end
      default: s_d.st = ACC_IDLE;
    endcase

    // read clears status, a set in the same cycle wins
    if (rd_go & (a8 == `ACC_OFF_STAT))
      s_d.stat = set_v;
    else
      s_d.stat = s_q.stat | set_v;
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    hreadyout = s_q.ready;
    hresp = 1'b0;
    hrdata = s_q.rdata;
    irq = s_q.irq;
    conv_active = s_q.st == ACC_CONV;
  end

  a_stop_no_store: assert property (@(posedge clk) disable iff (srst) // R1
    (s_q.st == ACC_CONV) && stop_wr |=> (s_q.st == ACC_IDLE) && !s_q.wpend && !s_q.dpend)
    else $error("stop did not abandon conversion");
  a_restart_reload: assert property (@(posedge clk) disable iff (srst) // R2
    (s_q.st == ACC_CONV) && !stop_wr && !s_q.wpend && tim_go
    |=> s_q.cyc == conv_cycles($past(s_q.mode1[`ACC_M1_FR])) && s_q.stat[`ACC_ST_ABAND])
    else $error("timer trigger did not restart conversion");
  a_trig_count: assert property (@(posedge clk) disable iff (srst) // R3
    tim_go |=> s_q.tcnt == $past(s_q.tcnt) + 8'h01)
    else $error("trigger not counted");
  a_gate_freeze: assert property (@(posedge clk) disable iff (srst) // R5
    (s_q.st == ACC_CONV) && gated && !stop_wr && !s_q.wpend && !tim_go |=> $stable(s_q.cyc) && s_q.susp)
    else $error("conversion ran while clock gated");
  a_halt_runs: assert property (@(posedge clk) disable iff (srst) // R4
    (s_q.st == ACC_CONV) && (s_q.sby == `ACC_SBY_HALT) && !stop_wr && !s_q.wpend && !tim_go
    && (s_q.cyc > 16'h0001) |=> s_q.cyc == $past(s_q.cyc) - 16'h0001)
    else $error("halt stopped conversion");
  // a back-to-back read of the same register may hold the store once more
  a_read_first: assert property (@(posedge clk) disable iff (srst) // R8
    s_q.wpend && rd_hit && !stop_wr |=> s_q.wpend ##1 (!s_q.wpend || $past(rd_hit)))
    else $error("result write did not wait for read");
  a_ext_ignored: assert property (@(posedge clk) disable iff (srst) // R9
    (s_q.st == ACC_CONV) && ext_edge |=> s_q.tcnt == $past(s_q.tcnt) || $past(tim_go))
    else $error("external edge taken during conversion");
  a_cfg_no_done: assert property (@(posedge clk) disable iff (srst) // R10
    s_q.dpend && cfg_wr && !(rd_go && (a8 == `ACC_OFF_STAT)) && !s_q.stat[`ACC_ST_DONE] |=> !s_q.stat[`ACC_ST_DONE])
    else $error("done raised despite config write");
  a_done_after: assert property (@(posedge clk) disable iff (srst) // R16
    commit && (s_q.st == ACC_CONV) |=> (s_q.st == ACC_IDLE) && s_q.dpend)
    else $error("store did not end conversion");
  a_cmp_irq: assert property (@(posedge clk) disable iff (srst) // R7
    compare_match_trigger && !(rd_go && (a8 == `ACC_OFF_STAT)) |=> s_q.stat[`ACC_ST_CMP])
    else $error("compare match status not set");

  // the R14 and R15 checks use raw pin levels and register fields, so a broken decode shows
  a_ext_start: assert property (@(posedge clk) disable iff (srst) // R14
    (s_q.st == ACC_IDLE) && (s_q.mode1[`ACC_M1_SRC] == `ACC_SRC_EXT) && s_q.mode0[`ACC_M0_RUN] && !gated
    && external_trigger_pin && !s_q.ext_q && (s_q.mode1[`ACC_M1_EDGE] != `ACC_EDGE_FALL) |=> (s_q.st == ACC_CONV))
    else $error("external rising edge did not start conversion");
  a_fall_start: assert property (@(posedge clk) disable iff (srst) // R15
    (s_q.st == ACC_IDLE) && (s_q.mode1[`ACC_M1_SRC] == `ACC_SRC_EXT) && s_q.mode0[`ACC_M0_RUN] && !gated
    && !external_trigger_pin && s_q.ext_q && (s_q.mode1[`ACC_M1_EDGE] != `ACC_EDGE_RISE) |=> (s_q.st == ACC_CONV))
    else $error("external falling edge did not start conversion");
  a_start_count: assert property (@(posedge clk) disable iff (srst) // R3
    (ext_go || sw_go) |=> s_q.tcnt == $past(s_q.tcnt) + 8'h01)
    else $error("start not counted");
  a_res_hold: assert property (@(posedge clk) disable iff (srst) // R1
    !commit |=> $stable(s_q.res))
    else $error("result changed without a finished conversion");
  a_susp_flag: assert property (@(posedge clk) disable iff (srst) // R6
    (s_q.st == ACC_CONV) && s_q.susp && !gated && !stop_wr && !s_q.wpend && !tim_go && (s_q.cyc == 16'h0001)
    |=> s_q.stat[`ACC_ST_SUSP])
    else $error("undefined result not flagged");
  a_nmi_keep: assert property (@(posedge clk) disable iff (srst) // R5
    nmi_release && !wr_dp |=> (s_q.sby == 2'h0) && $stable(s_q.mode0) && $stable(s_q.mode1) && $stable(s_q.chsel))
    else $error("release lost register contents");
  a_gate_no_start: assert property (@(posedge clk) disable iff (srst) // R5
    gated && (s_q.st == ACC_IDLE) |=> (s_q.st == ACC_IDLE))
    else $error("conversion started while clock gated");
  a_idle_clean: assert property (@(posedge clk) disable iff (srst) // R17
    (s_q.st == ACC_IDLE) |-> !s_q.wpend)
    else $error("store pending without active conversion");
  a_done_set: assert property (@(posedge clk) disable iff (srst) // R16
    s_q.dpend && !cfg_wr |=> s_q.stat[`ACC_ST_DONE])
    else $error("done status not raised after store");
  a_irq_level: assert property (@(posedge clk) disable iff (srst) // R7
    irq == |(s_q.stat & s_q.mask))
    else $error("interrupt level does not follow masked status");
endmodule
`default_nettype wire

/* rtl/acc_defines.svh */
// constants of the converter trigger and conflict control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFF_MODE0 8'h00
`define ACC_OFF_MODE1 8'h04
`define ACC_OFF_CHSEL 8'h08
`define ACC_OFF_STAT 8'h0C
`define ACC_OFF_MASK 8'h10
`define ACC_OFF_SBY 8'h14
`define ACC_RES_HI 3'h1
`define ACC_M0_RUN 0
`define ACC_M1_SRC 1:0
`define ACC_M1_EDGE 3:2
`define ACC_M1_FR 6:4
`define ACC_SRC_SW 2'h0
`define ACC_SRC_TIMER 2'h1
`define ACC_SRC_EXT 2'h2
`define ACC_EDGE_RISE 2'h0
`define ACC_EDGE_FALL 2'h1
`define ACC_ST_DONE 0
`define ACC_ST_CMP 1
`define ACC_ST_SUSP 2
`define ACC_ST_ABAND 3
`define ACC_SBY_HALT 2'h1
`define ACC_CONV_BASE 16'h0010
`define ACC_RES_W 10
`define ACC_NRES 8
`endif

/* rtl/acc_pkg.sv */
// types of the converter trigger and conflict control block
`include "acc_defines.svh"
package acc_pkg;
  typedef enum logic [0:0] {ACC_IDLE = 1'b0, ACC_CONV = 1'b1} acc_conv_e;
  typedef logic [`ACC_RES_W-1:0] acc_res_t;
  typedef struct packed {
    acc_conv_e st;
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [2:0] chsel;
    logic [1:0] sby;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [7:0] tcnt;
    logic [15:0] cyc;
    logic susp;
    logic wpend;
    acc_res_t wval;
    logic [2:0] widx;
    logic dpend;
    logic [`ACC_NRES-1:0][`ACC_RES_W-1:0] res;
    logic ext_q;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic irq;
    logic ready;
  } acc_state_s;
endpackage

/* tb/acc_src_model.sv */
// timer compare source, trigger pin driver and analog source for the converter
`timescale 1ns/10ps
`default_nettype none
module acc_src_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic pin_lvl,
  input wire acc_pkg::acc_res_t smp,
  output logic compare_match_trigger,
  output logic external_trigger_pin,
  output acc_pkg::acc_res_t analog_sample
);
  import acc_pkg::*;
  // spacing is the bench's choice, broken only on purpose
  always_ff @(posedge clk)
  begin
    compare_match_trigger <= fire;
    external_trigger_pin <= pin_lvl;
    // no port reads on the analog pins, the sample stays clean
    analog_sample <= smp;
  end
endmodule
`default_nettype wire

/* tb/acc_top_tb.sv */
// self-checking bench of the converter trigger and conflict control
`timescale 1ns/10ps
`default_nettype none
`include "acc_defines.svh"
`define CK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED t=%0t %h/%h", $time, a, e); end end
module acc_top_tb;
  import acc_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata, rd;
  logic [1:0] htrans = 0;
  logic [1:0] e;
  logic [2:0] ch, f;
  logic hwrite = 0, fire = 0, pin = 0, nmi = 0;
  logic hreadyout, hresp, irq, conv_active, cmp_t, ext_t;
  acc_res_t smp = 0;
  acc_res_t asmp, s;
  int failures = 0, checked = 0, cyc = 0;
  always #2.5 clk = ~clk;
  acc_top dut (.clk, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .compare_match_trigger(cmp_t),
    .external_trigger_pin(ext_t), .nmi_release(nmi), .analog_sample(asmp), .irq, .conv_active);
  acc_src_model m (.clk, .fire, .pin_lvl(pin), .smp, .compare_match_trigger(cmp_t),
    .external_trigger_pin(ext_t), .analog_sample(asmp));
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entered just after a rising edge; answer latency is never assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rst;
    srst <= 1;
    clks(20);
    srst <= 0;
    clks(2);
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (conv_active === 1'b1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    `CK(conv_active, 1'b0)
    clks(3);
  endtask
  function automatic logic [31:0] stat(input logic [3:0] b, input logic [7:0] n);
    return {8'h00, n, 12'h000, b};
  endfunction
  function automatic int conv_n(input logic [2:0] fs);
    return 16 << fs;
  endfunction
  task automatic pulse_nmi;
    nmi <= 1'b1;
    clks(1);
    nmi <= 1'b0;
    clks(1);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    void'($urandom(58));
    rst();
    `CK({irq, conv_active, hresp, hreadyout, hrdata}, 36'h1_0000_0000)
    $display("reset test done");
    ch = 3'($urandom_range(7));
    s = 10'($urandom);
    smp <= s;
    bus(1, `ACC_OFF_MODE1, 32'h0);
    bus(1, `ACC_OFF_CHSEL, {29'h0, ch});
    bus(1, `ACC_OFF_MODE0, 32'h1);
    clks(3);
    `CK(conv_active, 1'b1)
    wait_done();
    `CK(irq, 1'b0)
    bus(0, 8'h20 + {3'h0, ch, 2'h0}, 0);
    `CK(rd, {22'h0, s})
    bus(1, `ACC_OFF_MASK, 32'h1);
    clks(2);
    `CK(irq, 1'b1)
    bus(0, `ACC_OFF_STAT, 0);
    `CK(rd[3:0], 4'h1)
    clks(2);
    `CK(irq, 1'b0)
    $display("software test done");
    rst();
    bus(1, `ACC_OFF_MODE1, 32'h1);
    bus(1, `ACC_OFF_MASK, 32'hF);
    bus(1, `ACC_OFF_MODE0, 32'h1);
    fire <= 1;
    clks(1);
    fire <= 0;
    clks(5);
    `CK(conv_active, 1'b1)
    s = 10'($urandom);
    smp <= s;
    // second trigger well inside the conversion time
    fire <= 1;
    clks(1);
    fire <= 0;
    clks(14);
    `CK(conv_active, 1'b1)
    wait_done();
    `CK(irq, 1'b1)
    bus(0, 8'h20, 0);
    `CK(rd, {22'h0, s})
    bus(0, `ACC_OFF_STAT, 0);
    `CK(rd, stat(4'hB, 8'h02))
    $display("timer test done");
    rst();
    smp <= 10'($urandom) | 10'h001;
    bus(1, `ACC_OFF_MODE0, 32'h1);
    clks(4);
    bus(1, `ACC_OFF_MODE0, 32'h0);
    clks(2);
    `CK(conv_active, 1'b0)
    clks(20);
    bus(0, 8'h20, 0);
    `CK(rd, 32'h0)
    bus(0, `ACC_OFF_STAT, 0);
    `CK(rd[0], 1'b0)
    $display("stop test done");
    for (int j = 0; j < 2; j++)
    begin
      rst();
      f = 3'($urandom_range(2));
      ch = 3'($urandom_range(7));
      s = 10'($urandom) | 10'h001;
      smp <= s;
      bus(1, `ACC_OFF_MODE1, {25'h0, f, 4'h0});
      bus(1, `ACC_OFF_CHSEL, {29'h0, ch});
      bus(1, `ACC_OFF_MODE0, 32'h1);
      // next address phase lands on the cycle the result waits to be stored
      clks(conv_n(f));
      if (j == 0)
      begin
        bus(0, 8'h20 + {3'h0, ch, 2'h0}, 0);
        `CK(rd, 32'h0)
      end
      else
        bus(1, `ACC_OFF_CHSEL, {29'h0, ch});
      clks(3);
      bus(0, 8'h20 + {3'h0, ch, 2'h0}, 0);
      `CK(rd, {22'h0, s})
      bus(0, `ACC_OFF_STAT, 0);
      `CK(rd[0], j == 0)
    end
    $display("collision test done");
    rst();
    s = 10'($urandom) | 10'h001;
    smp <= s;
    bus(1, `ACC_OFF_SBY, 32'h1);
    bus(1, `ACC_OFF_MODE0, 32'h1);
    clks(2);
    `CK(conv_active, 1'b1)
    wait_done();
    pulse_nmi();
    bus(0, 8'h20, 0);
    `CK(rd, {22'h0, s})
    bus(0, `ACC_OFF_SBY, 0);
    `CK(rd, 32'h0)
    bus(1, `ACC_OFF_SBY, 32'h2);
    bus(1, `ACC_OFF_MODE0, 32'h1);
    clks(2);
    `CK(conv_active, 1'b0)
    pulse_nmi();
    bus(0, `ACC_OFF_MODE0, 0);
    `CK(rd, 32'h1)
    bus(0, 8'h20, 0);
    `CK(rd, {22'h0, s})
    bus(1, `ACC_OFF_MODE0, 32'h1);
    bus(1, `ACC_OFF_SBY, 32'h2);
    clks(40);
    `CK(conv_active, 1'b1)
    pulse_nmi();
    wait_done();
    bus(0, `ACC_OFF_STAT, 0);
    `CK(rd, stat(4'h5, 8'h02))
    $display("standby test done");
    for (int i = 0; i < 3; i++)
    begin
      e = i[1:0];
      rst();
      pin <= 0;
      bus(1, `ACC_OFF_MODE1, {28'h0, e, 2'h2});
      bus(1, `ACC_OFF_MODE0, 32'h1);
      clks(2);
      pin <= 1;
      clks(4);
      `CK(conv_active, e != 2'h1)
      wait_done();
      pin <= 0;
      clks(4);
      `CK(conv_active, e != 2'h0)
      if (conv_active === 1'b1)
      begin
        pin <= 1;
        clks(2);
        pin <= 0;
      end
      wait_done();
      bus(0, `ACC_OFF_STAT, 0);
      `CK(rd[23:16], (e == 2'h2) ? 8'h02 : 8'h01)
    end
    $display("external test done");
    end_of_test();
  end
endmodule
`default_nettype wire
